// ---- hdl/scu_pkg.sv ----
`default_nettype none
package scu_pkg;
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_IER = 8'h04;
    localparam logic [7:0] OFF_IIR = 8'h08;
    localparam logic [7:0] OFF_LCR = 8'h0C;
    localparam logic [7:0] OFF_SMR = 8'h10;
    localparam logic [7:0] OFF_LSR = 8'h14;
    localparam logic [7:0] OFF_SSR = 8'h18;
    localparam logic [7:0] OFF_UCR = 8'h30;

    localparam int LCR_DIVISOR_ACCESS_BIT = 7;
    localparam int LCR_EVEN = 4;
    localparam int LCR_PEN = 3;
    localparam int FCR_EN = 0;
    localparam int FCR_RXRST = 1;
    localparam int FCR_TXRST = 2;
    localparam int UCR_PORT_EN = 0;
    localparam int UCR_CARD_EN = 1;
    localparam int UCR_CLK_SEL = 4;
    localparam int SMR_BAUD_SEL = 0;
    localparam int IER_RX_DATA = 0;
    localparam int IER_TX_EMPTY = 1;
    localparam int IER_RX_LS = 2;
    localparam int IER_TX_LS = 3;
    localparam int IER_WAIT = 4;
    localparam int IER_CARD = 5;

    localparam logic [4:0] ID_NONE = 5'h01;
    localparam logic [4:0] ID_CARD = 5'h08;
    localparam logic [4:0] ID_RX_LS = 5'h06;
    localparam logic [4:0] ID_TX_LS = 5'h16;
    localparam logic [4:0] ID_RX_DATA = 5'h04;
    localparam logic [4:0] ID_RX_TO = 5'h14;
    localparam logic [4:0] ID_TX_EMPTY = 5'h02;
    localparam logic [4:0] ID_WAIT_TO = 5'h00;
    localparam logic [4:0] ID_INIT_FAIL = 5'h10;

    localparam logic [4:0] TRIG_00 = 5'h01;
    localparam logic [4:0] TRIG_01 = 5'h04;
    localparam logic [4:0] TRIG_10 = 5'h08;
    localparam logic [4:0] TRIG_11 = 5'h0E;

    localparam logic [4:0] OS_SEL0 = 5'h10;
    localparam logic [4:0] OS_SEL1 = 5'h1F;
    localparam logic [3:0] BIT_PARITY = 4'h9;
    localparam logic [3:0] BIT_GUARD = 4'hA;
    localparam int CHAR_BITS = 11;
    localparam int TIMEOUT_CHARS = 4;
    localparam logic [5:0] TIMEOUT_BITS = 6'(CHAR_BITS * TIMEOUT_CHARS);

    typedef enum logic [1:0] {ENG_IDLE, ENG_TX, ENG_RX} scu_eng_t;
endpackage
`default_nettype wire

// ---- hdl/scu_core.sv ----
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module scu_core
    import scu_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_in_a_en,
    input wire logic clk_in_b_en,
    input wire logic io_in,
    output logic io_out,
    output logic io_oe,
    input wire logic card_present,
    input wire logic wait_timeout_evt,
    input wire logic init_fail_evt,
    output logic port_interrupt_out
);
    import scu_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] rx_mem;
        logic [DEPTH-1:0][7:0] tx_mem;
        logic [AW-1:0] rx_rd;
        logic [AW-1:0] rx_wr;
        logic [AW-1:0] tx_rd;
        logic [AW-1:0] tx_wr;
        logic [AW:0] rx_cnt;
        logic [AW:0] tx_cnt;
        logic [15:0] div;
        logic [15:0] baud_cnt;
        logic [4:0] os_cnt;
        logic [7:0] interrupt_enable;
        logic [7:0] line_control;
        logic [1:0] trig;
        logic fifo_en;
        logic baud_sel;
        logic clk_sel;
        logic port_en;
        logic card_en;
        logic oe;
        logic pe;
        logic txpe;
        logic holding_empty_flag_int;
        logic rx_to;
        logic [5:0] to_cnt;
        logic card_chg;
        logic card_prev;
        logic init_fail;
        logic wait_to;
        scu_eng_t eng;
        logic [3:0] idx;
        logic [7:0] shift;
        logic io_out;
        logic io_oe;
        logic [7:0] rdata;
        logic err;
        logic holding_empty_flag_snap;
    } scu_state_t;

    scu_state_t st;
    scu_state_t next_st;

    logic setup;
    logic access;
    logic sc_mode;
    logic divisor_access_bit;
    logic mapped;
    logic [AW:0] fifo_lim;
    logic [4:0] trig_lvl;
    logic rx_avail;
    logic [4:0] irq_code;
    logic irq_pend;
    logic sel_en;
    logic baud_tick;
    logic [4:0] os_lim;
    logic bit_tick;
    logic mid_tick;
    logic rx_push;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic [2:0] bi;
    logic par;
    logic rx_flush;
    logic tx_flush;

    assign prdata = {24'h000000, st.rdata};
    assign pready = 1'b1;
    assign pslverr = access & st.err;
    assign io_out = st.io_out;
    assign io_oe = st.io_oe;
    assign port_interrupt_out = irq_pend;

    always_comb
    begin
        next_st = st;
        setup = psel & ~penable;
        access = psel & penable;
        sc_mode = st.port_en & st.card_en;
        divisor_access_bit = st.line_control[LCR_DIVISOR_ACCESS_BIT];
        mapped = (paddr == OFF_UCR) || (sc_mode && (paddr == OFF_DATA || paddr == OFF_IER
            || paddr == OFF_IIR || paddr == OFF_LCR || paddr == OFF_SMR
            || paddr == OFF_LSR || paddr == OFF_SSR));
        // Non-FIFO mode behaves as a one-entry buffer
        fifo_lim = st.fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
        unique case (st.trig)
            2'b00: trig_lvl = TRIG_00;
            2'b01: trig_lvl = TRIG_01;
            2'b10: trig_lvl = TRIG_10;
            2'b11: trig_lvl = TRIG_11;
        endcase
        rx_avail = st.fifo_en ? (32'(st.rx_cnt) >= 32'(trig_lvl)) : (st.rx_cnt != '0);
        irq_pend = 1'b1;
        if (st.card_chg && st.interrupt_enable[IER_CARD])
            irq_code = ID_CARD;
        else if ((st.oe || st.pe) && st.interrupt_enable[IER_RX_LS])
            irq_code = ID_RX_LS;
        else if (st.txpe && st.interrupt_enable[IER_TX_LS])
            irq_code = ID_TX_LS;
        else if (rx_avail && st.interrupt_enable[IER_RX_DATA])
            irq_code = ID_RX_DATA;
        else if (st.rx_to && st.interrupt_enable[IER_RX_DATA])
            irq_code = ID_RX_TO;
        else if (st.holding_empty_flag_int && st.interrupt_enable[IER_TX_EMPTY])
            irq_code = ID_TX_EMPTY;
        else if (st.wait_to && st.interrupt_enable[IER_WAIT])
            irq_code = ID_WAIT_TO;
        else if (st.init_fail && st.interrupt_enable[IER_WAIT])
            irq_code = ID_INIT_FAIL;
        else
        begin
            irq_code = ID_NONE;
            irq_pend = 1'b0;
        end

        sel_en = st.clk_sel ? clk_in_b_en : clk_in_a_en;
        // Down count with reload; divisors below two tick every input clock
        baud_tick = sel_en && (st.baud_cnt <= 16'h0001);
        if (sel_en)
            next_st.baud_cnt = baud_tick ? st.div : st.baud_cnt - 16'h0001;
        os_lim = st.baud_sel ? OS_SEL1 : OS_SEL0;
        bit_tick = baud_tick && (st.os_cnt == os_lim - 5'h01);
        mid_tick = baud_tick && (st.os_cnt == (os_lim >> 1));
        if (baud_tick)
            next_st.os_cnt = bit_tick ? 5'h00 : st.os_cnt + 5'h01;

        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_flush = 1'b0;
        tx_flush = 1'b0;
        bi = 3'(st.idx - 4'h1);
        par = st.line_control[LCR_EVEN] ? ^st.shift : ~^st.shift;

        // Register reads are captured in the setup phase, so the answer is a flop
        if (setup && !pwrite)
        begin
            next_st.err = ~mapped;
            next_st.holding_empty_flag_snap = 1'b0;
            next_st.rdata = 8'h00;
            if (mapped)
            begin
                unique case (paddr)
                    OFF_DATA: next_st.rdata = divisor_access_bit ? st.div[7:0] : st.rx_mem[st.rx_rd];
                    OFF_IER: next_st.rdata = divisor_access_bit ? st.div[15:8] : {2'b00, st.interrupt_enable[5:0]};
                    OFF_IIR:
                    begin
                        next_st.rdata = {st.fifo_en, st.fifo_en, 1'b0, irq_code};
                        next_st.holding_empty_flag_snap = (irq_code == ID_TX_EMPTY);
                    end
                    OFF_LCR: next_st.rdata = st.line_control;
                    OFF_SMR: next_st.rdata = {7'h00, st.baud_sel};
                    OFF_LSR: next_st.rdata = {st.fifo_en & (st.pe | st.oe),
                        (st.tx_cnt == '0) && (st.eng != ENG_TX), st.tx_cnt == '0,
                        st.txpe, 1'b0, st.pe, st.oe, st.rx_cnt != '0};
                    OFF_SSR: next_st.rdata = {5'h00, st.wait_to, st.init_fail, card_present};
                    OFF_UCR: next_st.rdata = {3'h0, st.clk_sel, 2'h0, st.card_en, st.port_en};
                    default: next_st.rdata = 8'h00;
                endcase
            end
        end
        else if (setup)
            next_st.err = ~mapped;

        // Side effects happen only when the access phase completes
        if (access && !st.err && !pwrite)
        begin
            unique case (paddr)
                OFF_DATA: rx_pop = ~divisor_access_bit && (st.rx_cnt != '0);
                OFF_LSR:
                begin
                    next_st.oe = 1'b0;
                    next_st.pe = 1'b0;
                    next_st.txpe = 1'b0;
                end
                OFF_SSR:
                begin
                    next_st.card_chg = 1'b0;
                    next_st.wait_to = 1'b0;
                    next_st.init_fail = 1'b0;
                end
                OFF_IIR:
                    if (st.holding_empty_flag_snap)
                        next_st.holding_empty_flag_int = 1'b0;
                default: ;
            endcase
        end
        if (access && !st.err && pwrite)
        begin
            unique case (paddr)
                OFF_DATA:
                    if (divisor_access_bit)
                    begin
                        next_st.div[7:0] = pwdata[7:0];
                        next_st.baud_cnt = {st.div[15:8], pwdata[7:0]};
                    end
                    else
                    begin
                        tx_push = (st.tx_cnt != fifo_lim);
                        next_st.holding_empty_flag_int = 1'b0;
                    end
                OFF_IER:
                    if (divisor_access_bit)
                    begin
                        next_st.div[15:8] = pwdata[7:0];
                        next_st.baud_cnt = {pwdata[7:0], st.div[7:0]};
                    end
                    else
                        next_st.interrupt_enable = {2'b00, pwdata[5:0]};
                OFF_IIR:
                begin
                    next_st.fifo_en = pwdata[FCR_EN];
                    // Disable or mode change flushes both
                    if (!pwdata[FCR_EN] || (pwdata[FCR_EN] != st.fifo_en))
                    begin
                        rx_flush = 1'b1;
                        tx_flush = 1'b1;
                    end
                    if (pwdata[FCR_EN])
                        next_st.trig = pwdata[7:6];
                    if (pwdata[FCR_EN] && pwdata[FCR_RXRST])
                        rx_flush = 1'b1;
                    if (pwdata[FCR_EN] && pwdata[FCR_TXRST])
                        tx_flush = 1'b1;
                end
                OFF_LCR: next_st.line_control = pwdata[7:0];
                OFF_SMR: next_st.baud_sel = pwdata[SMR_BAUD_SEL];
                OFF_UCR:
                begin
                    next_st.port_en = pwdata[UCR_PORT_EN];
                    next_st.card_en = pwdata[UCR_CARD_EN];
                    next_st.clk_sel = pwdata[UCR_CLK_SEL];
                end
                default: ;
            endcase
        end

        // Half-duplex engine: one shifter serves both directions
        unique case (st.eng)
            ENG_IDLE:
            begin
                next_st.io_oe = 1'b0;
                if (sc_mode && baud_tick && !io_in)
                begin
                    next_st.eng = ENG_RX;
                    next_st.idx = 4'h0;
                    next_st.os_cnt = 5'h00;
                end
                else if (sc_mode && bit_tick && (st.tx_cnt != '0))
                begin
                    tx_pop = 1'b1;
                    next_st.shift = st.tx_mem[st.tx_rd];
                    next_st.eng = ENG_TX;
                    next_st.idx = 4'h0;
                    next_st.io_out = 1'b0;
                    next_st.io_oe = 1'b1;
                end
            end
            ENG_TX:
            begin
                if (bit_tick)
                begin
                    next_st.idx = st.idx + 4'h1;
                    if (st.idx < 4'h8)
                        next_st.io_out = st.shift[st.idx[2:0]];
                    else if (st.idx == 4'h8)
                        next_st.io_out = par;
                    else if (st.idx == BIT_PARITY)
                    begin
                        next_st.io_out = 1'b1;
                        next_st.io_oe = 1'b0;
                    end
                    else
                        next_st.eng = ENG_IDLE;
                end
                // Card signals a parity error by holding the line low in the guard bit
                if (mid_tick && (st.idx == BIT_GUARD) && !io_in)
                    next_st.txpe = 1'b1;
            end
            ENG_RX:
                if (mid_tick)
                begin
                    next_st.idx = st.idx + 4'h1;
                    if (st.idx == 4'h0)
                    begin
                        if (io_in)
                            next_st.eng = ENG_IDLE;
                    end
                    else if (st.idx <= 4'h8)
                        next_st.shift[bi] = io_in;
                    else if (st.idx == BIT_PARITY)
                    begin
                        if (st.line_control[LCR_PEN] && (io_in != par))
                            next_st.pe = 1'b1;
                    end
                    else
                    begin
                        next_st.eng = ENG_IDLE;
                        if (st.rx_cnt == fifo_lim)
                            next_st.oe = 1'b1;
                        else
                            rx_push = 1'b1;
                    end
                end
            default: next_st.eng = ENG_IDLE;
        endcase

        if (rx_push)
        begin
            next_st.rx_mem[st.rx_wr] = st.shift;
            next_st.rx_wr = st.rx_wr + AW'(1);
        end
        if (rx_pop)
            next_st.rx_rd = st.rx_rd + AW'(1);
        if (rx_push != rx_pop)
            next_st.rx_cnt = rx_push ? st.rx_cnt + (AW+1)'(1) : st.rx_cnt - (AW+1)'(1);
        if (tx_push)
        begin
            next_st.tx_mem[st.tx_wr] = pwdata[7:0];
            next_st.tx_wr = st.tx_wr + AW'(1);
        end
        if (tx_pop)
            next_st.tx_rd = st.tx_rd + AW'(1);
        if (tx_push != tx_pop)
            next_st.tx_cnt = tx_push ? st.tx_cnt + (AW+1)'(1) : st.tx_cnt - (AW+1)'(1);
        // Flush beats same-cycle push or pop, keeping count and pointers aligned
        if (rx_flush)
        begin
            next_st.rx_cnt = '0;
            next_st.rx_rd = '0;
            next_st.rx_wr = '0;
        end
        if (tx_flush)
        begin
            next_st.tx_cnt = '0;
            next_st.tx_rd = '0;
            next_st.tx_wr = '0;
        end
        // Empty event wins over a same-cycle clear
        if (tx_pop && !tx_push && (st.tx_cnt == (AW+1)'(1)))
            next_st.holding_empty_flag_int = 1'b1;

        // Character timeout, counted in bit times
        if (rx_push || rx_pop || !st.fifo_en || (st.rx_cnt == '0))
        begin
            next_st.to_cnt = 6'h00;
            next_st.rx_to = 1'b0;
        end
        else if (bit_tick && !st.rx_to)
        begin
            next_st.to_cnt = st.to_cnt + 6'h01;
            if (st.to_cnt + 6'h01 >= TIMEOUT_BITS)
                next_st.rx_to = 1'b1;
        end

        // Card edges; sets placed last so they beat clears
        next_st.card_prev = card_present;
        if (card_present != st.card_prev)
            next_st.card_chg = 1'b1;
        // Waiting time and init fail events
        if (wait_timeout_evt)
            next_st.wait_to = 1'b1;
        if (init_fail_evt)
            next_st.init_fail = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    a_iir_idle_code: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup && !pwrite && paddr == OFF_IIR && mapped && !irq_pend)
        |=> st.rdata[5:0] == {1'b0, ID_NONE})
        else $error("idle identification code wrong");
    a_card_first: assert property (@(posedge clk_sys) disable iff (!resetn)
        (st.card_chg && st.interrupt_enable[IER_CARD]) |-> (irq_code == ID_CARD && port_interrupt_out))
        else $error("card change not at top priority");
    a_rx_ls_code: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!(st.card_chg && st.interrupt_enable[IER_CARD]) && st.pe && st.interrupt_enable[IER_RX_LS])
        |-> irq_code == ID_RX_LS)
        else $error("receive line status code wrong");
    a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        (st.interrupt_enable[5:0] == 6'h00) |-> (!port_interrupt_out && irq_code == ID_NONE))
        else $error("disabled source raised interrupt");
    a_iir_frozen: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup && !pwrite && paddr == OFF_IIR && mapped)
        |=> st.rdata[4:0] == $past(irq_code) && st.rdata[7:6] == {2{$past(st.fifo_en)}})
        else $error("identification read not frozen");
    a_fcr_flush: assert property (@(posedge clk_sys) disable iff (!resetn)
        (access && pwrite && !st.err && paddr == OFF_IIR && !pwdata[FCR_EN])
        |=> (st.rx_cnt == '0 && st.tx_cnt == '0 && !st.fifo_en))
        else $error("FIFO disable did not flush");
    a_div_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        (access && pwrite && !st.err && paddr == OFF_DATA && divisor_access_bit)
        |=> (st.baud_cnt == st.div && st.div[7:0] == $past(pwdata[7:0])))
        else $error("divisor write did not load counter");
    a_ier_top_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (access && pwrite && !st.err && paddr == OFF_IER && !divisor_access_bit)
        |=> (st.interrupt_enable[7:6] == 2'b00 && st.interrupt_enable[5:0] == $past(pwdata[5:0])))
        else $error("enable register write wrong");
    a_bit_ratio: assert property (@(posedge clk_sys) disable iff (!resetn)
        bit_tick |-> st.os_cnt == (st.baud_sel ? 5'h1E : 5'h0F))
        else $error("bit period not 16 or 31 ticks");
endmodule
`default_nettype wire

// ---- verif/scu_card_model.sv ----
`default_nettype none
module scu_card_model #(
    parameter int BIT = 16
)
(
    input wire logic clk_sys,
    input wire logic line,
    input wire logic dut_oe,
    output logic pull_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] got;
    int frames = 0;
    // Bit length in clocks, retuned by the bench for the 31-tick ratio
    int bit_len = BIT;
    initial pull_low = 1'b0;
    // Parity slot between data and guard
    task automatic send(input logic [7:0] d, input logic bad);
        logic [10:0] f;
        f = {1'b1, ^d ^ bad, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            pull_low <= !f[i];
            repeat (bit_len) @(posedge clk_sys);
        end
    endtask
    always @(posedge dut_oe)
    begin
        repeat (bit_len / 2) @(posedge clk_sys);
        for (int i = 0; i < 9; i++)
        begin
            repeat (bit_len) @(posedge clk_sys);
            got[i] = line;
        end
        // Let the guard bit pass, so a reply cannot look like an error signal
        repeat (2 * bit_len) @(posedge clk_sys);
        frames++;
    end
endmodule
`default_nettype wire

// ---- verif/smart_card_uart_core_tb.sv ----
`default_nettype none
module smart_card_uart_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, resetn, psel, penable, pwrite, io_out, io_oe, pready, pslverr, irq;
    logic card_present, wait_evt, fail_evt, card_low, clk_b_en, err_seen;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata;
    wire logic io_line;
    int bad_count = 0;
    int checks_done = 0;
    // Line has a pull-up when nobody drives it
    assign io_line = io_oe ? io_out : !card_low;
    scu_core #(.DEPTH(16)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_in_a_en(1'b1), .clk_in_b_en(clk_b_en),
        .io_in(io_line), .io_out(io_out), .io_oe(io_oe), .card_present(card_present),
        .wait_timeout_evt(wait_evt), .init_fail_evt(fail_evt), .port_interrupt_out(irq));
    scu_card_model #(.BIT(16)) u_card (.clk_sys(clk_sys), .line(io_line), .dut_oe(io_oe),
        .pull_low(card_low));
    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        q = prdata[7:0];
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, q});
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        stop_test();
    end
    initial
    begin
        {psel, penable, pwrite, card_present, wait_evt, fail_evt, clk_b_en} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        resetn = 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        xfer(1'b1, 8'h04, 8'h3F);
        chk("pslverr", 9'h001, {8'h00, err_seen});
        xfer(1'b1, 8'h30, 8'h03);
        chk("pslverr", 9'h000, {8'h00, err_seen});
        rc(8'h04, 8'h00);
        rc(8'h08, 8'h01);
        xfer(1'b1, 8'h0C, 8'h80);
        xfer(1'b1, 8'h00, 8'h01);
        xfer(1'b1, 8'h04, 8'hA5);
        rc(8'h04, 8'hA5);
        xfer(1'b1, 8'h04, 8'h00);
        rc(8'h00, 8'h01);
        xfer(1'b1, 8'h0C, 8'h1B);
        xfer(1'b1, 8'h10, 8'h00);
        xfer(1'b1, 8'h04, 8'hFF);
        rc(8'h04, 8'h3F);
        xfer(1'b1, 8'h08, 8'h41);
        rc(8'h08, 8'hC1);
        xfer(1'b1, 8'h00, 8'h97);
        for (int n = 0; n < 400 && u_card.frames == 0; n++) @(posedge clk_sys);
        chk("tx frame", {^8'h97, 8'h97}, u_card.got);
        rc(8'h08, 8'hC2);
        rc(8'h08, 8'hC1);
        for (int i = 0; i < 3; i++) u_card.send(8'h30 + 8'(i), 1'b0);
        rc(8'h08, 8'hC1);
        u_card.send(8'h33, 1'b0);
        rc(8'h08, 8'hC4);
        rc(8'h00, 8'h30);
        rc(8'h08, 8'hC1);
        repeat (800) @(posedge clk_sys);
        rc(8'h08, 8'hD4);
        for (int i = 1; i < 4; i++) rc(8'h00, 8'h30 + 8'(i));
        rc(8'h08, 8'hC1);
        xfer(1'b1, 8'h08, 8'h03);
        u_card.send(8'h5C, 1'b1);
        rc(8'h08, 8'hC6);
        xfer(1'b0, 8'h14, 8'h00);
        rc(8'h08, 8'hC4);
        xfer(1'b1, 8'h08, 8'h03);
        rc(8'h08, 8'hC1);
        // Input clock B is held still, so the character must wait
        xfer(1'b1, 8'h30, 8'h13);
        rc(8'h30, 8'h13);
        xfer(1'b1, 8'h10, 8'h01);
        rc(8'h10, 8'h01);
        xfer(1'b1, 8'h00, 8'h66);
        repeat (40) @(posedge clk_sys);
        rc(8'h14, 8'h00);
        xfer(1'b1, 8'h08, 8'h05);
        rc(8'h14, 8'h60);
        xfer(1'b1, 8'h00, 8'h5A);
        u_card.bit_len = 31;
        clk_b_en <= 1'b1;
        for (int n = 0; n < 600 && u_card.frames < 2; n++) @(posedge clk_sys);
        chk("tx frame 31", {^8'h5A, 8'h5A}, u_card.got);
        rc(8'h08, 8'hC2);
        xfer(1'b1, 8'h08, 8'h00);
        rc(8'h08, 8'h01);
        xfer(1'b1, 8'h04, 8'h1F);
        card_present <= 1'b1;
        rc(8'h08, 8'h01);
        chk("irq", 9'h000, {8'h00, irq});
        xfer(1'b1, 8'h04, 8'h3F);
        rc(8'h08, 8'h08);
        rc(8'h18, 8'h01);
        rc(8'h08, 8'h01);
        wait_evt <= 1'b1;
        @(posedge clk_sys);
        wait_evt <= 1'b0;
        rc(8'h08, 8'h00);
        chk("irq", 9'h001, {8'h00, irq});
        xfer(1'b0, 8'h18, 8'h00);
        fail_evt <= 1'b1;
        @(posedge clk_sys);
        fail_evt <= 1'b0;
        rc(8'h08, 8'h10);
        xfer(1'b0, 8'h18, 8'h00);
        rc(8'h08, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
